// ### rtl/mdcr_pkg.sv
// package of offsets, fields, reset values and types for the dma control registers
package mdcr_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_BUS_ACCESS = 8'h00;
  localparam logic [7:0] OFF_TX_POLL = 8'h08;
  localparam logic [7:0] OFF_RX_POLL = 8'h10;
  localparam logic [7:0] OFF_RX_BASE = 8'h18;
  localparam logic [7:0] OFF_TX_BASE = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h28;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h38;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_SOFT_RESET = 0;
  localparam int BIT_FATAL = 13;
  localparam int BIT_RESET_DONE = 12;
  localparam int POS_RX_STATE = 17;
  localparam int POS_TX_STATE = 20;
  localparam int POS_FAULT_KIND = 23;
  localparam int RING_LSB = 2;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [31:0] POLL_RESET = 32'h0FFFFFFF;
  localparam logic [29:0] RING_RESET = 30'h00000000;
  localparam logic [1:0] RING_ALIGN = 2'h0;
  localparam logic [2:0] FAULT_PARITY = 3'h0;
  localparam logic [2:0] FAULT_MASTER_ABORT = 3'h1;
  localparam logic [2:0] FAULT_TARGET_ABORT = 3'h2;
  localparam logic [2:0] PROC_STOPPED = 3'h0;
  localparam logic [2:0] TX_SUSPENDED = 3'h6;
  localparam logic [2:0] RX_SUSPENDED = 3'h4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam logic [7:0] SOFT_RESET_CYCLES = 8'h10;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_BUSY = 2'b10
  } mdcr_seq_t;

  typedef struct packed {
    logic [2:0] tx_state;
    logic [2:0] rx_state;
  } mdcr_proc_state_t;

  typedef struct packed {
    logic valid;
    logic [2:0] kind;
  } mdcr_fault_t;

  typedef struct packed {
    mdcr_seq_t seq;
    logic [7:0] seq_cnt;
    logic soft_reset_bit;
    logic [31:0] tx_poll;
    logic [31:0] rx_poll;
    logic [29:0] rx_ring_start;
    logic [29:0] tx_ring_start;
    logic [2:0] bus_fault_kind;
    logic fatal_bus_fault_flag;
    logic reset_done_flag;
    logic bus_off;
    logic mask_fatal;
    logic mask_done;
    logic [31:0] prdata;
    logic rd_loaded;
    logic tx_poll_kick;
    logic rx_poll_kick;
  } mdcr_state_t;

endpackage

// ### rtl/mdcr_regs.sv
// apb register bank of the dma engine: soft reset, poll demands, ring bases, status
//
// Our own choice: the APB register port.
`timescale 1ns/1ps

// Function
// - writing one to the soft reset bit resets the engine and the poll, ring base and irq mask registers
// - the soft reset bit clears itself once the reset sequence ends
// - tx poll write while tx suspended pulses the tx descriptor fetch kick
// - rx poll write while rx suspended pulses the rx descriptor fetch kick
// - rx ring base holds bits 31 to 2, bits 1 and 0 read zero
// - tx ring base holds bits 31 to 2, bits 1 and 0 read zero
// - fault kind field valid only with fatal flag; it raises no interrupt
// - fault kind codes: 000 parity, 001 master abort, 010 target abort
// - a bus fault sets the fatal flag and blocks bus access until reset
module mdcr_regs
  import mdcr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire mdcr_proc_state_t proc_state,
  input wire mdcr_fault_t bus_fault,
  output logic tx_poll_kick,
  output logic rx_poll_kick,
  output logic [31:0] rx_ring_base,
  output logic [31:0] tx_ring_base,
  output logic engine_reset,
  output logic bus_access_enable,
  output logic irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mdcr_state_t st;
  mdcr_state_t next_st;

  logic [7:0] addr;
  logic setup;
  logic access_done;
  logic wr_done;
  logic rd_done;
  logic mapped;
  logic [31:0] status_word;
  logic [31:0] mask_word;
  logic [31:0] rd_word;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign addr = paddr[7:0];
  assign setup = psel && !penable;
  assign access_done = psel && penable && clk_en && st.rd_loaded;
  assign wr_done = access_done && pwrite;
  assign rd_done = access_done && !pwrite;

  always_comb begin
    mapped = 1'b0;
    if (paddr[31:8] == 24'h000000) begin
      unique case (addr)
        OFF_BUS_ACCESS, OFF_TX_POLL, OFF_RX_POLL, OFF_RX_BASE,
        OFF_TX_BASE, OFF_STATUS, OFF_IRQ_MASK: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read words
  // ----------------------------------------------------------------
  always_comb begin
    status_word = 32'h00000000;
    status_word[POS_FAULT_KIND +: 3] = st.bus_fault_kind;
    status_word[POS_TX_STATE +: 3] = proc_state.tx_state;
    status_word[POS_RX_STATE +: 3] = proc_state.rx_state;
    status_word[BIT_FATAL] = st.fatal_bus_fault_flag;
    status_word[BIT_RESET_DONE] = st.reset_done_flag;
  end

  always_comb begin
    mask_word = 32'h00000000;
    mask_word[BIT_FATAL] = st.mask_fatal;
    mask_word[BIT_RESET_DONE] = st.mask_done;
  end

  always_comb begin
    rd_word = 32'h00000000;
    if (mapped) begin
      unique case (addr)
        OFF_BUS_ACCESS: rd_word[BIT_SOFT_RESET] = st.soft_reset_bit;
        OFF_TX_POLL: rd_word = st.tx_poll;
        OFF_RX_POLL: rd_word = st.rx_poll;
        OFF_RX_BASE: rd_word = {st.rx_ring_start, RING_ALIGN};
        OFF_TX_BASE: rd_word = {st.tx_ring_start, RING_ALIGN};
        OFF_STATUS: rd_word = status_word;
        OFF_IRQ_MASK: rd_word = mask_word;
        default: rd_word = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.tx_poll_kick = 1'b0;
    next_st.rx_poll_kick = 1'b0;

    // read data captured in setup, answered in the access phase
    if (setup) begin
      next_st.rd_loaded = 1'b1;
      next_st.prdata = pwrite ? 32'h00000000 : rd_word;
    end
    if (access_done) begin
      next_st.rd_loaded = 1'b0;
    end

    // read of status clears sticky bits; a new event below wins
    if (rd_done && mapped && addr == OFF_STATUS) begin
      next_st.fatal_bus_fault_flag = 1'b0;
      next_st.reset_done_flag = 1'b0;
    end

    if (wr_done && mapped) begin
      unique case (addr)
        OFF_BUS_ACCESS: begin
          if (pwdata[BIT_SOFT_RESET] && st.seq == SEQ_IDLE) begin
            next_st.soft_reset_bit = 1'b1;
            next_st.seq = SEQ_BUSY;
            next_st.seq_cnt = SOFT_RESET_CYCLES;
          end
        end
        OFF_TX_POLL: begin
          next_st.tx_poll = pwdata;
          if (proc_state.tx_state == TX_SUSPENDED && st.seq == SEQ_IDLE) begin
            next_st.tx_poll_kick = 1'b1;
          end
        end
        OFF_RX_POLL: begin
          next_st.rx_poll = pwdata;
          if (proc_state.rx_state == RX_SUSPENDED && st.seq == SEQ_IDLE) begin
            next_st.rx_poll_kick = 1'b1;
          end
        end
        OFF_RX_BASE: next_st.rx_ring_start = pwdata[31:RING_LSB];
        OFF_TX_BASE: next_st.tx_ring_start = pwdata[31:RING_LSB];
        OFF_IRQ_MASK: begin
          next_st.mask_fatal = pwdata[BIT_FATAL];
          next_st.mask_done = pwdata[BIT_RESET_DONE];
        end
        default: next_st.tx_poll_kick = 1'b0;
      endcase
    end

    // engine reset sequence
    unique case (st.seq)
      SEQ_IDLE: begin
        next_st.seq_cnt = next_st.seq_cnt;
      end
      SEQ_BUSY: begin
        // hold the engine state cleared for the whole sequence
        next_st.tx_poll = POLL_RESET;
        next_st.rx_poll = POLL_RESET;
        next_st.rx_ring_start = RING_RESET;
        next_st.tx_ring_start = RING_RESET;
        next_st.bus_fault_kind = FAULT_PARITY;
        next_st.fatal_bus_fault_flag = 1'b0;
        next_st.bus_off = 1'b0;
        next_st.mask_fatal = 1'b0;
        next_st.mask_done = 1'b0;
        if (st.seq_cnt == 8'h01) begin
          next_st.seq = SEQ_IDLE;
          next_st.soft_reset_bit = 1'b0;
          next_st.seq_cnt = 8'h00;
          next_st.reset_done_flag = 1'b1;
        end else begin
          next_st.seq_cnt = st.seq_cnt - 8'h01;
        end
      end
      default: begin
        next_st.seq = SEQ_IDLE;
        next_st.seq_cnt = 8'h00;
      end
    endcase

    // fatal bus fault: sticky flag, kind latched, bus blocked
    if (bus_fault.valid && st.seq == SEQ_IDLE) begin
      next_st.fatal_bus_fault_flag = 1'b1;
      next_st.bus_off = 1'b1;
      next_st.bus_fault_kind = bus_fault.kind;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.seq <= SEQ_IDLE;
      st.seq_cnt <= 8'h00;
      st.soft_reset_bit <= 1'b0;
      st.tx_poll <= POLL_RESET;
      st.rx_poll <= POLL_RESET;
      st.rx_ring_start <= RING_RESET;
      st.tx_ring_start <= RING_RESET;
      st.bus_fault_kind <= FAULT_PARITY;
      st.fatal_bus_fault_flag <= 1'b0;
      st.reset_done_flag <= 1'b0;
      st.bus_off <= 1'b0;
      st.mask_fatal <= 1'b0;
      st.mask_done <= 1'b0;
      st.prdata <= 32'h00000000;
      st.rd_loaded <= 1'b0;
      st.tx_poll_kick <= 1'b0;
      st.rx_poll_kick <= 1'b0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = st.prdata;
  assign pready = psel && penable && clk_en && st.rd_loaded;
  assign pslverr = pready && !mapped;
  assign tx_poll_kick = st.tx_poll_kick;
  assign rx_poll_kick = st.rx_poll_kick;
  assign rx_ring_base = {st.rx_ring_start, RING_ALIGN};
  assign tx_ring_base = {st.tx_ring_start, RING_ALIGN};
  assign engine_reset = st.soft_reset_bit;
  assign bus_access_enable = !st.bus_off && !st.soft_reset_bit;
  // fault kind field itself feeds no interrupt
  assign irq = (st.fatal_bus_fault_flag && st.mask_fatal) ||
               (st.reset_done_flag && st.mask_done);

endmodule

// ### testbench/mdcr_props.sv
// port checker of the dma control register bank
`timescale 1ns/1ps
module mdcr_props
  import mdcr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire mdcr_proc_state_t proc_state,
  input wire mdcr_fault_t bus_fault,
  input wire logic tx_poll_kick,
  input wire logic rx_poll_kick,
  input wire logic [31:0] rx_ring_base,
  input wire logic [31:0] tx_ring_base,
  input wire logic engine_reset,
  input wire logic bus_access_enable
);
  logic wr;
  assign wr = psel && penable && pready && pwrite && !engine_reset;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  srst_start_a: assert property (wr && paddr == 32'h0 && pwdata[0] |=> engine_reset && !bus_access_enable) else $error("soft reset not started");
  srst_end_a: assert property ($rose(engine_reset) |-> engine_reset [*8] ##[8:10] !engine_reset) else $error("soft reset length wrong");
  tx_kick_a: assert property (wr && paddr == {24'h0, OFF_TX_POLL} && proc_state.tx_state == TX_SUSPENDED |=> tx_poll_kick) else $error("tx kick missing");
  tx_cause_a: assert property (tx_poll_kick |-> $past(proc_state.tx_state) == TX_SUSPENDED ##1 !tx_poll_kick) else $error("tx kick without cause");
  rx_kick_a: assert property (wr && paddr == {24'h0, OFF_RX_POLL} && proc_state.rx_state == RX_SUSPENDED |=> rx_poll_kick ##1 !rx_poll_kick) else $error("rx kick wrong");
  rx_base_a: assert property (wr && paddr == {24'h0, OFF_RX_BASE} |=> rx_ring_base == {$past(pwdata[31:2]), RING_ALIGN}) else $error("rx base wrong");
  tx_base_a: assert property (wr && paddr == {24'h0, OFF_TX_BASE} |=> tx_ring_base == {$past(pwdata[31:2]), RING_ALIGN}) else $error("tx base wrong");
  fault_off_a: assert property (bus_fault.valid && !engine_reset |=> !bus_access_enable) else $error("bus not disabled");
  off_hold_a: assert property ($rose(bus_access_enable) |-> $past(engine_reset) || $past(engine_reset, 2)) else $error("bus enabled early");
endmodule
bind mdcr_regs mdcr_props u_mdcr_props(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .proc_state, .bus_fault, .tx_poll_kick, .rx_poll_kick, .rx_ring_base, .tx_ring_base,
  .engine_reset, .bus_access_enable);

// ### testbench/mdcr_engine_model.sv
// behavioural dma engine: process states and bus fault pulses
`timescale 1ns/1ps
module mdcr_engine_model
  import mdcr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [5:0] want_state,
  input wire logic fault_go,
  input wire logic [2:0] fault_kind,
  output mdcr_proc_state_t proc_state,
  output mdcr_fault_t bus_fault
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      proc_state <= '0;
      bus_fault <= '0;
    end else begin
      proc_state <= want_state;
      bus_fault.valid <= fault_go;
      bus_fault.kind <= fault_go ? fault_kind : ~bus_fault.kind;
    end
  end
endmodule

// ### testbench/mac_dma_control_registers_test.sv
// self-checking bench of the dma control register bank
`timescale 1ns/1ps
module mac_dma_control_registers_test;
  import mdcr_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [5:0] want_state = 6'h0;
  logic fault_go = 1'b0;
  logic [2:0] fault_kind = 3'h0;
  logic [31:0] prdata, rx_ring_base, tx_ring_base, rdat;
  logic pready, pslverr, tx_poll_kick, rx_poll_kick, engine_reset, bus_access_enable, irq, rerr;
  mdcr_proc_state_t proc_state;
  mdcr_fault_t bus_fault;
  int failures = 0;
  int checked = 0;
  always #10 pclk = ~pclk;
  mdcr_regs u_mdcr_regs(.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .proc_state, .bus_fault, .tx_poll_kick, .rx_poll_kick,
    .rx_ring_base, .tx_ring_base, .engine_reset, .bus_access_enable, .irq);
  mdcr_engine_model u_mdcr_engine_model(.pclk, .presetn, .want_state, .fault_go, .fault_kind,
    .proc_state, .bus_fault);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task summarize();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rerr = pslverr;
    rdat = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task t_reset();
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, 32'h8 * (i + 1), 32'h0);
      chk(rdat, i < 2 ? POLL_RESET : 32'h0);
    end
    xfer(1'b0, 32'h4, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    chk({engine_reset, bus_access_enable, irq}, 3'h2);
    $display("test reset done");
  endtask
  task t_base();
    for (int i = 0; i < 2; i++) begin
      xfer(1'b1, i ? OFF_TX_BASE : OFF_RX_BASE, 32'hA5A5A5A7);
      xfer(1'b0, i ? OFF_TX_BASE : OFF_RX_BASE, 32'h0);
      chk(rdat, 32'hA5A5A5A4);
      chk(i ? tx_ring_base : rx_ring_base, 32'hA5A5A5A4);
    end
    $display("test base done");
  endtask
  task t_kick();
    for (int i = 0; i < 4; i++) begin
      want_state <= (i == 0 || i == 3) ? {TX_SUSPENDED, PROC_STOPPED} : {PROC_STOPPED, RX_SUSPENDED};
      xfer(1'b1, i < 2 ? OFF_TX_POLL : OFF_RX_POLL, 32'h12345670 + i);
      @(negedge pclk);
      chk({tx_poll_kick, rx_poll_kick}, i == 0 ? 2'h2 : i == 2 ? 2'h1 : 2'h0);
      @(negedge pclk);
      chk({tx_poll_kick, rx_poll_kick}, 2'h0);
      xfer(1'b0, i < 2 ? OFF_TX_POLL : OFF_RX_POLL, 32'h0);
      chk(rdat, 32'h12345670 + i);
    end
    want_state <= 6'h0;
    $display("test kick done");
  endtask
  task t_fault();
    xfer(1'b1, OFF_IRQ_MASK, 32'h2000);
    for (int k = 0; k < 3; k++) begin
      fault_kind <= 3'(k);
      fault_go <= 1'b1;
      @(posedge pclk);
      fault_go <= 1'b0;
      @(posedge pclk);
      @(negedge pclk);
      chk({bus_access_enable, irq}, 2'h1);
      xfer(1'b0, OFF_STATUS, 32'h0);
      chk(rdat & 32'h03802000, (k << 23) | 32'h2000);
      @(negedge pclk);
      chk(irq, 1'b0);
    end
    $display("test fault done");
  endtask
  task t_srst();
    int n;
    n = 0;
    xfer(1'b1, OFF_BUS_ACCESS, 32'h1);
    @(negedge pclk);
    chk({engine_reset, bus_access_enable}, 2'h2);
    while (engine_reset === 1'b1 && n < 100) begin
      n++;
      @(negedge pclk);
    end
    chk(n, SOFT_RESET_CYCLES);
    xfer(1'b0, OFF_BUS_ACCESS, 32'h0);
    chk(rdat, 32'h0);
    xfer(1'b0, OFF_TX_POLL, 32'h0);
    chk({31'h0, bus_access_enable}, 32'h1);
    chk(tx_ring_base, 32'h0);
    chk(rdat, POLL_RESET);
    xfer(1'b0, OFF_STATUS, 32'h0);
    chk(rdat & 32'h3000, 32'h1000);
    $display("test soft reset done");
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_base();
    t_kick();
    t_fault();
    t_srst();
    summarize();
  end
  initial begin
    #100000;
    failures++;
    summarize();
  end
endmodule
